/* File: verilog/mlg_pkg.sv */
package mlg_pkg;

  localparam int LFSR_W = 24;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_POLY   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SEED   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_DATA   = 8'h14;

  // control and status fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_SEL_LSB   = 1;
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_CMP_BIT   = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_FULL_BIT  = 3;
  localparam int STAT_LEVEL_LSB = 8;

  // reset values
  localparam logic [LFSR_W-1:0] RST_POLY  = 24'h000000;
  localparam logic [LFSR_W-1:0] RST_SEED  = 24'h000000;
  localparam logic [LFSR_W-1:0] RST_SHIFT = 24'h000000;
  localparam logic              RST_RUN   = 1'h0;

  // sample maximal-length polynomials
  localparam logic [LFSR_W-1:0] POLY_8BIT  = 24'h0000B8;
  localparam logic [LFSR_W-1:0] POLY_16BIT = 24'h00B400;
  localparam logic [LFSR_W-1:0] POLY_24BIT = 24'hD80000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_LE = 2'h1,
    CMP_LT = 2'h2
  } mlg_cmp_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WRESP = 2'h1,
    ST_RRESP = 2'h2
  } mlg_bus_t;

  // ones on every bit up to the highest polynomial bit: the effective length
  function automatic logic [LFSR_W-1:0] span_mask(input logic [LFSR_W-1:0] p);
    logic [LFSR_W-1:0] m;
    m = p;
    for (int i = 0; i < LFSR_W; i++) begin
      m = m | (m >> 1);
    end
    return m;
  endfunction

  // byte lanes 0..2 land on the lower, middle and upper byte slices
  function automatic logic [LFSR_W-1:0] merge_bytes(input logic [LFSR_W-1:0] old_v,
                                                    input logic [31:0]       wd,
                                                    input logic [3:0]        strb);
    logic [LFSR_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: verilog/mlg_step.sv */
module mlg_step import mlg_pkg::*; (
  input  wire logic [LFSR_W-1:0] cur_state,  // present shift value
  input  wire logic [LFSR_W-1:0] poly,       // tap polynomial
  output logic      [LFSR_W-1:0] next_state  // value after one advance
);

  // galois form: the feedback bit is xored in after every stage whose tap is set
  always_comb begin
    next_state = {1'b0, cur_state[LFSR_W-1:1]} ^ (cur_state[0] ? poly : '0);
  end

endmodule // mlg_step

/* File: verilog/mlg_fifo.sv */
module mlg_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,        // system clock
  input  wire logic          srst,       // synchronous reset
  input  wire logic          in_valid,   // push request
  output logic               in_ready,   // room for a word
  input  wire logic [W-1:0]  in_data,    // pushed word
  output logic               out_valid,  // word available
  input  wire logic          out_ready,  // pop request
  output logic      [W-1:0]  out_data,   // oldest word
  output logic      [AW:0]   level       // words held
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]   cnt_ff,    nxt_cnt;
  logic          push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_comb begin
    in_ready   = (cnt_ff != (AW+1)'(DEPTH));
    out_valid  = (cnt_ff != '0);
    out_data   = mem[rd_ptr_ff];
    level      = cnt_ff;
    push       = in_valid && in_ready;
    pop        = out_ready && out_valid;
    nxt_wr_ptr = push ? bump(wr_ptr_ff) : wr_ptr_ff;
    nxt_rd_ptr = pop ? bump(rd_ptr_ff) : rd_ptr_ff;
    nxt_cnt    = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

endmodule // mlg_fifo

/* File: verilog/mlg_top.sv */
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
module mlg_top import mlg_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              CLK_SYS,        // system clock
  input  wire logic              SRST,           // synchronous reset, high
  input  wire logic              STEP_CLK,       // sequence clock, sampled
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,   // write address
  input  wire logic              S_AXI_AWVALID,  // write address valid
  output logic                   S_AXI_AWREADY,  // write address ready
  input  wire logic [31:0]       S_AXI_WDATA,    // write data
  input  wire logic [3:0]        S_AXI_WSTRB,    // write byte strobes
  input  wire logic              S_AXI_WVALID,   // write data valid
  output logic                   S_AXI_WREADY,   // write data ready
  output logic [1:0]             S_AXI_BRESP,    // write response
  output logic                   S_AXI_BVALID,   // write response valid
  input  wire logic              S_AXI_BREADY,   // write response ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,   // read address
  input  wire logic              S_AXI_ARVALID,  // read address valid
  output logic                   S_AXI_ARREADY,  // read address ready
  output logic [31:0]            S_AXI_RDATA,    // read data
  output logic [1:0]             S_AXI_RRESP,    // read response
  output logic                   S_AXI_RVALID,   // read data valid
  input  wire logic              S_AXI_RREADY,   // read data ready
  output logic                   SERIAL_OUT,     // serial bit stream
  output logic                   COMPARE_OUT     // sync compare, active high
);

  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  // bus group
  mlg_bus_t          state_ff,   nxt_state;
  logic              aw_got_ff,  nxt_aw_got;
  logic              w_got_ff,   nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
  logic [31:0]       wdata_ff,   nxt_wdata;
  logic [3:0]        wstrb_ff,   nxt_wstrb;
  logic              awready_ff, nxt_awready;
  logic              wready_ff,  nxt_wready;
  logic              arready_ff, nxt_arready;
  logic              bvalid_ff,  nxt_bvalid;
  logic [1:0]        bresp_ff,   nxt_bresp;
  logic              rvalid_ff,  nxt_rvalid;
  logic [31:0]       rdata_ff,   nxt_rdata;
  logic [1:0]        rresp_ff,   nxt_rresp;
  logic              wr_fire, rd_fire;
  logic [ADDR_W-1:0] rd_addr;

  // core group
  logic [LFSR_W-1:0] poly_ff,    nxt_poly;
  logic [LFSR_W-1:0] seed_ff,    nxt_seed;
  logic [LFSR_W-1:0] shift_ff,   nxt_shift;
  logic              run_ff,     nxt_run;
  mlg_cmp_t          sel_ff,     nxt_sel;
  logic              step_q_ff,  nxt_step_q;
  logic              serial_ff,  nxt_serial;
  logic              cmp_ff,     nxt_cmp;
  logic [LFSR_W-1:0] step_next, len_mask, wr_merged;
  logic              step_rise, step_go, seed_in_range, cmp_hit;

  // fifo of stepped values
  logic              fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [LFSR_W-1:0] fifo_out_data;
  logic [LVL_W-1:0]  fifo_level;

  mlg_step u_step (
    .cur_state  (shift_ff),
    .poly       (poly_ff),
    .next_state (step_next)
  );

  mlg_fifo #(
    .W     (LFSR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .in_valid  (step_rise && run_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (step_next),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // read data and response for one address
  function automatic logic [33:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    r = RESP_OKAY;
    unique case (a)
      ADDR_POLY:   d[LFSR_W-1:0] = poly_ff;
      ADDR_SHIFT:  d[LFSR_W-1:0] = shift_ff;
      ADDR_SEED:   d[LFSR_W-1:0] = seed_ff;
      ADDR_CTRL: begin
        d[CTRL_RUN_BIT]        = run_ff;
        d[CTRL_SEL_LSB +: 2]   = sel_ff;
      end
      ADDR_STATUS: begin
        d[STAT_RUN_BIT]             = run_ff;
        d[STAT_CMP_BIT]             = cmp_ff;
        d[STAT_EMPTY_BIT]           = !fifo_out_valid;
        d[STAT_FULL_BIT]            = !fifo_in_ready;
        d[STAT_LEVEL_LSB +: LVL_W]  = fifo_level;
      end
      ADDR_DATA:   d[LFSR_W-1:0] = fifo_out_valid ? fifo_out_data : '0;
      default:     r = RESP_SLVERR;
    endcase
    return {r, d};
  endfunction

  always_comb begin
    nxt_state  = state_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    wr_fire    = 1'b0;
    rd_fire    = 1'b0;
    rd_addr    = S_AXI_ARADDR;
    unique case (state_ff)
      ST_IDLE: begin
        if (S_AXI_AWVALID && awready_ff) begin
          nxt_aw_got = 1'b1;
          nxt_awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_ff) begin
          nxt_w_got = 1'b1;
          nxt_wdata = S_AXI_WDATA;
          nxt_wstrb = S_AXI_WSTRB;
        end
        if (S_AXI_ARVALID && arready_ff) begin
          rd_fire                = 1'b1;
          {nxt_rresp, nxt_rdata} = read_word(S_AXI_ARADDR);
          nxt_rvalid             = 1'b1;
          nxt_state              = ST_RRESP;
        end else if (aw_got_ff && w_got_ff) begin
          wr_fire    = 1'b1;
          nxt_aw_got = 1'b0;
          nxt_w_got  = 1'b0;
          nxt_bvalid = 1'b1;
          nxt_bresp  = (awaddr_ff inside {ADDR_POLY, ADDR_SHIFT, ADDR_SEED, ADDR_CTRL, ADDR_STATUS, ADDR_DATA})
                       ? RESP_OKAY : RESP_SLVERR;
          nxt_state  = ST_WRESP;
        end
      end
      ST_WRESP: begin
        if (S_AXI_BREADY) begin
          nxt_bvalid = 1'b0;
          nxt_state  = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (S_AXI_RREADY) begin
          nxt_rvalid = 1'b0;
          nxt_state  = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_awready = (nxt_state == ST_IDLE) && !nxt_aw_got;
    nxt_wready  = (nxt_state == ST_IDLE) && !nxt_w_got;
    nxt_arready = (nxt_state == ST_IDLE) && !(nxt_aw_got && nxt_w_got);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state_ff   <= ST_IDLE;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      state_ff   <= nxt_state;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  always_comb begin
    nxt_poly      = poly_ff;
    nxt_seed      = seed_ff;
    nxt_shift     = shift_ff;
    nxt_run       = run_ff;
    nxt_sel       = sel_ff;
    nxt_step_q    = STEP_CLK;
    step_rise     = STEP_CLK && !step_q_ff;
    // a full fifo swallows the edge, so the sequence stalls until drained
    step_go       = run_ff && step_rise && fifo_in_ready;
    fifo_pop      = rd_fire && (rd_addr == ADDR_DATA);
    len_mask      = span_mask(poly_ff);
    wr_merged     = '0;
    if (step_go) begin
      nxt_shift = step_next;
    end
    if (rd_fire && (rd_addr == ADDR_SHIFT)) begin
      nxt_seed = shift_ff;
    end
    if (wr_fire) begin
      unique case (awaddr_ff)
        ADDR_POLY: begin
          wr_merged = merge_bytes(poly_ff, wdata_ff, wstrb_ff);
          nxt_poly  = wr_merged;
        end
        ADDR_SEED: begin
          wr_merged = merge_bytes(seed_ff, wdata_ff, wstrb_ff);
          nxt_seed  = wr_merged;
          if (!run_ff) begin
            nxt_shift = wr_merged;
          end
        end
        ADDR_CTRL: begin
          wr_merged = merge_bytes({{(LFSR_W-3){1'b0}}, sel_ff, run_ff}, wdata_ff, wstrb_ff);
          nxt_run   = wr_merged[CTRL_RUN_BIT];
          nxt_sel   = (wr_merged[CTRL_SEL_LSB +: 2] == 2'h3) ? CMP_EQ : mlg_cmp_t'(wr_merged[CTRL_SEL_LSB +: 2]);
        end
        default: wr_merged = '0;
      endcase
    end
    seed_in_range = (seed_ff <= len_mask) && (poly_ff != '0);
    unique case (sel_ff)
      CMP_EQ:  cmp_hit = (shift_ff == seed_ff);
      CMP_LE:  cmp_hit = (shift_ff <= seed_ff);
      CMP_LT:  cmp_hit = (shift_ff < seed_ff);
      default: cmp_hit = 1'b0;
    endcase
    nxt_cmp    = seed_in_range && cmp_hit;
    nxt_serial = |(shift_ff & len_mask & ~(len_mask >> 1));
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      poly_ff   <= RST_POLY;
      seed_ff   <= RST_SEED;
      shift_ff  <= RST_SHIFT;
      run_ff    <= RST_RUN;
      sel_ff    <= CMP_EQ;
      step_q_ff <= 1'b0;
      serial_ff <= 1'b0;
      cmp_ff    <= 1'b0;
    end else begin
      poly_ff   <= nxt_poly;
      seed_ff   <= nxt_seed;
      shift_ff  <= nxt_shift;
      run_ff    <= nxt_run;
      sel_ff    <= nxt_sel;
      step_q_ff <= nxt_step_q;
      serial_ff <= nxt_serial;
      cmp_ff    <= nxt_cmp;
    end
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY  = wready_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign SERIAL_OUT    = serial_ff;
  assign COMPARE_OUT   = cmp_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_reset_clears: assert property ($past(SRST) |-> !run_ff && poly_ff == '0 && seed_ff == '0 && shift_ff == '0)
    else $error("state not cleared by reset");
  a_seed_loads_shift: assert property (wr_fire && awaddr_ff == ADDR_SEED && !run_ff |=> shift_ff == seed_ff)
    else $error("stopped seed write did not load shift");
  a_seed_keeps_shift: assert property (wr_fire && awaddr_ff == ADDR_SEED && run_ff && !step_go |=> $stable(shift_ff))
    else $error("running seed write disturbed shift");
  a_step_advances: assert property (step_go |=> shift_ff == $past(step_next))
    else $error("enabled edge did not advance shift");
  a_galois_form: assert property (step_go && shift_ff[0] |=> shift_ff == (($past(shift_ff) >> 1) ^ $past(poly_ff)))
    else $error("feedback not xored into tapped stages");
  a_no_zero_lock: assert property (step_go && shift_ff != '0 && shift_ff <= len_mask |=> shift_ff != '0)
    else $error("sequence fell into zero");
  a_len_bound: assert property (step_go && shift_ff <= len_mask |=> shift_ff <= len_mask)
    else $error("shift left the programmed length");
  a_shift_latch: assert property (rd_fire && rd_addr == ADDR_SHIFT |=> seed_ff == $past(shift_ff))
    else $error("shift read did not latch into seed");
  a_out_of_range: assert property (seed_ff > len_mask |=> !COMPARE_OUT)
    else $error("compare asserted for unreachable seed");
  a_cmp_equal: assert property (sel_ff == CMP_EQ && shift_ff == seed_ff && seed_in_range |=> COMPARE_OUT)
    else $error("equal compare missed");
  a_cmp_less: assert property (sel_ff == CMP_LT && shift_ff >= seed_ff |=> !COMPARE_OUT)
    else $error("less-than compare wrong");
  a_serial_tap: assert property (poly_ff == POLY_8BIT ##1 poly_ff == POLY_8BIT |-> SERIAL_OUT == $past(shift_ff[7]))
    else $error("serial output not top tap");
  a_slice_write: assert property (wr_fire && awaddr_ff == ADDR_POLY && wstrb_ff[2:0] == 3'h1
                                  |=> poly_ff[23:8] == $past(poly_ff[23:8]))
    else $error("byte strobe touched other slices");

  c_step: cover property (step_go ##[1:20] step_go);
  c_sync: cover property (run_ff && COMPARE_OUT);
  c_reseed_run: cover property (wr_fire && awaddr_ff == ADDR_SEED && run_ff);
  c_fifo_full: cover property (run_ff && !fifo_in_ready);

endmodule // mlg_top

/* File: tb/mlg_host.sv */
module mlg_host import mlg_pkg::*; (
  input  wire logic              clk,      // system clock
  output logic      [ADDR_W-1:0] awaddr,   // write address
  output logic                   awvalid,  // write address valid
  input  wire logic              awready,  // write address ready
  output logic      [31:0]       wdata,    // write data
  output logic      [3:0]        wstrb,    // byte strobes
  output logic                   wvalid,   // write data valid
  input  wire logic              wready,   // write data ready
  input  wire logic [1:0]        bresp,    // write response
  input  wire logic              bvalid,   // response valid
  output logic                   bready,   // response ready
  output logic      [ADDR_W-1:0] araddr,   // read address
  output logic                   arvalid,  // read address valid
  input  wire logic              arready,  // read address ready
  input  wire logic [31:0]       rdata,    // read data
  input  wire logic [1:0]        rresp,    // read response
  input  wire logic              rvalid,   // read data valid
  output logic                   rready,   // read data ready
  output logic                   hung      // a wait ran out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
  end

  // released address and data show their inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    int   n;
    logic aw_p;
    logic w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 1000) begin
      @(posedge clk);
      n++;
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~v;
      end
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n >= 1000) hung <= 1'b1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] resp);
    int   n;
    logic ar_p;
    n = 0;
    ar_p = 1'b1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 1000) begin
      @(posedge clk);
      n++;
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 1000) hung <= 1'b1;
  endtask
endmodule // mlg_host

/* File: tb/mlg_top_tb.sv */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end

module mlg_top_tb import mlg_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          WIDS  [4] = '{2, 3, 4, 8};
  localparam logic [23:0] POLYS [4] = '{24'h000003, 24'h000006, 24'h00000C, POLY_8BIT};
  localparam mlg_cmp_t    SELS  [3] = '{CMP_EQ, CMP_LE, CMP_LT};
  localparam logic        CMPX  [3] = '{1'h0, 1'h1, 1'h1};
  logic              clk, srst, step_clk, ser, cmp, cmp_q, hung;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rs;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [23:0]       m;
  int                fails, n_compared, n_rise;

  mlg_top #(.FIFO_DEPTH(4)) u_mlg_top (.CLK_SYS(clk), .SRST(srst), .STEP_CLK(step_clk),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SERIAL_OUT(ser), .COMPARE_OUT(cmp));
  mlg_host u_mlg_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cmp_q <= cmp;
    if (cmp === 1'b1 && cmp_q === 1'b0) n_rise++;
  end

  always @(posedge hung) begin
    fails++;
    wrap_up();
  end

  function automatic logic [23:0] nx(input logic [23:0] s, input logic [23:0] p);
    return (s >> 1) ^ (s[0] ? p : 24'h000000);
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    u_mlg_host.wr(a, v, 4'hF, rs);
    `CHK(rs, RESP_OKAY)
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    u_mlg_host.rd(a, d, rs);
    `CHK(d, e)
    `CHK(rs, RESP_OKAY)
  endtask

  task automatic step();
    @(posedge clk);
    step_clk <= 1'b1;
    repeat (2) @(posedge clk);
    step_clk <= 1'b0;
    @(posedge clk);
  endtask

  // walks one whole sequence from seed 1 and counts its length
  task automatic period(input int n, input logic [23:0] p);
    int          k;
    logic [23:0] e;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_POLY, {8'h00, p});
    wr(ADDR_SEED, 32'h1);
    rd_chk(ADDR_SHIFT, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    n_rise = 0;
    e = 24'h000001;
    for (k = 1; k <= (1 << n); k++) begin
      step();
      e = nx(e, p);
      rd_chk(ADDR_DATA, {8'h00, e});
      `CHK(ser, e[n-1])
      if (d[23:0] === 24'h000001) break;
    end
    `CHK(k, (1 << n) - 1)
    `CHK(n_rise, 1)
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    step_clk = 1'b0;
    fails = 0;
    n_compared = 0;
    n_rise = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_POLY, 32'h0);
    rd_chk(ADDR_SEED, 32'h0);
    rd_chk(ADDR_SHIFT, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_STATUS, 32'h00000004);
    $display("reset test done");
    wr(ADDR_POLY, 32'hFFFFFFFF);
    rd_chk(ADDR_POLY, 32'h00FFFFFF);
    u_mlg_host.wr(ADDR_POLY, 32'h00001100, 4'h2, rs);
    `CHK(rs, RESP_OKAY)
    rd_chk(ADDR_POLY, 32'h00FF11FF);
    u_mlg_host.wr(8'h18, 32'h1, 4'hF, rs);
    `CHK(rs, RESP_SLVERR)
    u_mlg_host.rd(8'h18, d, rs);
    `CHK(rs, RESP_SLVERR)
    wr(ADDR_CTRL, 32'h6);
    rd_chk(ADDR_CTRL, 32'h0);
    $display("register test done");
    for (int i = 0; i < 4; i++) period(WIDS[i], POLYS[i]);
    $display("sequence test done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_POLY, {8'h00, POLY_8BIT});
    wr(ADDR_SEED, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    repeat (6) step();
    rd_chk(ADDR_STATUS, 32'h00000409);
    wr(ADDR_CTRL, 32'h0);
    m = 24'h000001;
    repeat (4) m = nx(m, POLY_8BIT);
    rd_chk(ADDR_SHIFT, {8'h00, m});
    rd_chk(ADDR_SEED, {8'h00, m});
    m = 24'h000001;
    for (int i = 0; i < 4; i++) begin
      m = nx(m, POLY_8BIT);
      rd_chk(ADDR_DATA, {8'h00, m});
    end
    rd_chk(ADDR_STATUS, 32'h00000006);
    $display("buffer test done");
    wr(ADDR_POLY, 32'h00000CA0);
    wr(ADDR_SEED, 32'h00000800);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_SEED, 32'h00000900);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {29'h0, SELS[i], 1'b1});
      repeat (2) @(posedge clk);
      `CHK(cmp, CMPX[i])
    end
    wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_SEED, 32'h00000900);
    rd_chk(ADDR_SHIFT, 32'h00000800);
    wr(ADDR_SEED, 32'h00001000);
    wr(ADDR_CTRL, 32'h3);
    step();
    repeat (2) @(posedge clk);
    `CHK(cmp, 1'b0)
    $display("compare test done");
    wrap_up();
  end
endmodule // mlg_top_tb
